// file: hw/caa_pkg.sv
// Package: register map, field layout and reset values of the alarm aggregator
package caa_pkg;

  // ==========================================================================
  // Register indices and bus address width
  localparam logic [11:0] CAA_IDX_SUMMARY = 12'h2C0;
  localparam logic [11:0] CAA_IDX_FLAGS   = 12'h2C1;
  localparam logic [11:0] CAA_IDX_MASK    = 12'h2C2;
  localparam logic [11:0] CAA_IDX_SEL     = 12'h2C3;
  localparam logic [11:0] CAA_IDX_IRQ_ST  = 12'h2C4;
  localparam logic [11:0] CAA_IDX_IRQ_EN  = 12'h2C5;
  localparam int          CAA_ADDR_W      = 14;

  // ==========================================================================
  // Field positions
  localparam int CAA_NFLAG       = 5;
  localparam int CAA_BIT_DIVMIS  = 0;
  localparam int CAA_BIT_OSC     = 1;
  localparam int CAA_BIT_REALIGN = 2;
  localparam int CAA_BIT_LINK    = 3;
  localparam int CAA_BIT_PLL     = 4;
  localparam int CAA_BIT_SUMMARY = 0;
  localparam int CAA_BIT_PINSEL  = 0;
  localparam int CAA_NIRQ        = 1;

  // ==========================================================================
  // Reset values
  localparam logic [4:0] CAA_FLAGS_RST  = 5'h1F;
  localparam logic [4:0] CAA_MASK_RST   = 5'h1F;
  localparam logic       CAA_SEL_RST    = 1'h0;
  localparam logic       CAA_IRQ_EN_RST = 1'h0;

  // ==========================================================================
  // Bus access state
  typedef enum logic [1:0] {
    CAA_BUS_IDLE = 2'b01,
    CAA_BUS_DONE = 2'b10
  } caa_bus_state_t;

endpackage : caa_pkg

// file: hw/caa_sync.sv
// Two-flop synchroniser bank for the asynchronous fault inputs
`timescale 1ns/1ns
module caa_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  // ==========================================================================
  // First stage is read only by the second
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : caa_sync

// file: hw/caa_top.sv
// Converter alarm aggregator: sticky fault flags, mask, summary and APB slave
`timescale 1ns/1ns
// Notes on behaviour
// [R01] Summary bit is OR of unmasked flags
// [R02] Selected summary drives calibration status pin
// [R03] PLL unlocked sets bit 4, sticky
// [R04] Link enabled outside data encoding sets bit 3
// [R05] Clock realignment event sets bit 2
// [R06] Oscillator disable, sync or mismatch sets bit 1
// [R07] Channel divider mismatch sets bit 0
// [R08] Writing one clears a status flag
// [R09] Status flags reset to 0x1F
// [R10] Set mask bit hides its flag
// [R11] Mask bits reset to 0x1F
// [R12] Summary register read only, upper bits reserved
// [R13] Zero write keeps flag; fault beats clear
module caa_top
  import caa_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CAA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  pll_locked,
  input  wire logic                  serial_link_enable,
  input  wire logic                  data_encoding_state,
  input  wire logic                  clock_realign_event,
  input  wire logic                  osc_sync_event,
  input  wire logic                  osc_phase_mismatch,
  input  wire logic                  divider_mismatch,
  output logic                       calibration_status_pin,
  output logic                       irq
);

  // ==========================================================================
  // Fault input synchronisation
  logic [6:0] raw_in;
  logic [6:0] syn;
  logic [4:0] fault_now;

  assign raw_in = {pll_locked, serial_link_enable, data_encoding_state,
                   clock_realign_event, osc_sync_event, osc_phase_mismatch,
                   divider_mismatch};

  caa_sync #(.W(7)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // Event inputs are level-sampled; sources hold them for at least 3 cycles
  always_comb begin
    fault_now                  = '0;
    fault_now[CAA_BIT_PLL]     = ~syn[6];                                   // R03
    fault_now[CAA_BIT_LINK]    = syn[5] & ~syn[4];                          // R04
    fault_now[CAA_BIT_REALIGN] = syn[3];                                    // R05
    fault_now[CAA_BIT_OSC]     = ~syn[5] | syn[2] | syn[1];                 // R06
    fault_now[CAA_BIT_DIVMIS]  = syn[0];                                    // R07
  end

  // ==========================================================================
  // Register address decode
  function automatic logic hit(input logic [CAA_ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a[1:0] == 2'h0) && (a[CAA_ADDR_W-1:2] == idx);
  endfunction : hit

  caa_bus_state_t bus_r;
  caa_bus_state_t bus_nxt;
  logic           acc;
  logic           wr;
  logic           rd;
  logic           mapped;

  // One wait state keeps every answer registered
  assign acc    = psel & penable & (bus_r == CAA_BUS_IDLE);
  assign wr     = acc & pwrite & pstrb[0];
  assign rd     = acc & ~pwrite;
  assign mapped = hit(paddr, CAA_IDX_SUMMARY) | hit(paddr, CAA_IDX_FLAGS) |
                  hit(paddr, CAA_IDX_MASK) | hit(paddr, CAA_IDX_SEL) |
                  hit(paddr, CAA_IDX_IRQ_ST) | hit(paddr, CAA_IDX_IRQ_EN);

  // ==========================================================================
  // Alarm state
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic [4:0] mask_r;
  logic [4:0] mask_nxt;
  logic       sel_r;
  logic       sel_nxt;
  logic       summary;
  logic       sum_r;
  logic       sum_nxt;
  logic       irq_st_r;
  logic       irq_st_nxt;
  logic       irq_en_r;
  logic       irq_en_nxt;
  logic       sum_rise;
  logic [4:0] clr;

  assign summary  = |(flags_r & ~mask_r);                                   // R01 R10
  assign sum_rise = summary & ~sum_r;
  assign clr      = (wr && hit(paddr, CAA_IDX_FLAGS)) ? pwdata[4:0] : 5'h00; // R08

  always_comb begin
    flags_nxt  = (flags_r & ~clr) | fault_now;                              // R08 R13
    mask_nxt   = mask_r;
    sel_nxt    = sel_r;
    irq_en_nxt = irq_en_r;
    sum_nxt    = summary;
    if (wr && hit(paddr, CAA_IDX_MASK)) begin
      mask_nxt = pwdata[4:0];                                               // R10
    end
    if (wr && hit(paddr, CAA_IDX_SEL)) begin
      sel_nxt = pwdata[CAA_BIT_PINSEL];
    end
    if (wr && hit(paddr, CAA_IDX_IRQ_EN)) begin
      irq_en_nxt = pwdata[0];
    end
    // A rising summary that meets a clearing read stays set
    irq_st_nxt = irq_st_r;
    if (rd && hit(paddr, CAA_IDX_IRQ_ST)) begin
      irq_st_nxt = 1'b0;
    end
    if (sum_rise) begin
      irq_st_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_r  <= CAA_FLAGS_RST;                                            // R09
      mask_r   <= CAA_MASK_RST;                                             // R11
      sel_r    <= CAA_SEL_RST;
      irq_en_r <= CAA_IRQ_EN_RST;
      irq_st_r <= 1'b0;
      sum_r    <= 1'b0;
    end else begin
      flags_r  <= flags_nxt;
      mask_r   <= mask_nxt;
      sel_r    <= sel_nxt;
      irq_en_r <= irq_en_nxt;
      irq_st_r <= irq_st_nxt;
      sum_r    <= sum_nxt;
    end
  end

  // ==========================================================================
  // Bus answer and output pins
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        pin_nxt;
  logic        irq_nxt;

  always_comb begin
    bus_nxt     = (acc) ? CAA_BUS_DONE : CAA_BUS_IDLE;
    pready_nxt  = acc;
    pslverr_nxt = acc & ~mapped;
    prdata_nxt  = 32'h0000_0000;
    if (rd) begin
      if (hit(paddr, CAA_IDX_SUMMARY)) begin
        prdata_nxt[CAA_BIT_SUMMARY] = summary;                              // R12
      end
      if (hit(paddr, CAA_IDX_FLAGS)) begin
        prdata_nxt[4:0] = flags_r;
      end
      if (hit(paddr, CAA_IDX_MASK)) begin
        prdata_nxt[4:0] = mask_r;
      end
      if (hit(paddr, CAA_IDX_SEL)) begin
        prdata_nxt[0] = sel_r;
      end
      if (hit(paddr, CAA_IDX_IRQ_ST)) begin
        prdata_nxt[0] = irq_st_r;
      end
      if (hit(paddr, CAA_IDX_IRQ_EN)) begin
        prdata_nxt[0] = irq_en_r;
      end
    end
    pin_nxt = sel_r & summary;                                              // R02
    irq_nxt = irq_st_r & irq_en_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_r                  <= CAA_BUS_IDLE;
      prdata                 <= 32'h0000_0000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      calibration_status_pin <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      bus_r                  <= bus_nxt;
      prdata                 <= prdata_nxt;
      pready                 <= pready_nxt;
      pslverr                <= pslverr_nxt;
      calibration_status_pin <= pin_nxt;
      irq                    <= irq_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // Checks the registered read path, not the combinational term itself
  property p_summary_or;
    @(posedge clk) disable iff (!reset_n)
      (pready && !pwrite && !pslverr && hit(paddr, CAA_IDX_SUMMARY)) |->
        (prdata[CAA_BIT_SUMMARY] == $past(|(flags_r & ~mask_r)));
  endproperty
  a_summary_or: assert property (p_summary_or) else $error("summary mismatch"); // R01

  property p_pin;
    @(posedge clk) disable iff (!reset_n)
      (sel_r && summary) |=> calibration_status_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("status pin not driven"); // R02

  property p_pll;
    @(posedge clk) disable iff (!reset_n)
      !syn[6] |=> flags_r[CAA_BIT_PLL];
  endproperty
  a_pll: assert property (p_pll) else $error("pll flag not set"); // R03

  property p_link;
    @(posedge clk) disable iff (!reset_n)
      (syn[5] && !syn[4]) |=> flags_r[CAA_BIT_LINK];
  endproperty
  a_link: assert property (p_link) else $error("link flag not set"); // R04

  property p_realign;
    @(posedge clk) disable iff (!reset_n)
      syn[3] |=> flags_r[CAA_BIT_REALIGN];
  endproperty
  a_realign: assert property (p_realign) else $error("realign flag not set"); // R05

  property p_osc;
    @(posedge clk) disable iff (!reset_n)
      (!syn[5] || syn[2] || syn[1]) |=> flags_r[CAA_BIT_OSC];
  endproperty
  a_osc: assert property (p_osc) else $error("osc flag not set"); // R06

  property p_div;
    @(posedge clk) disable iff (!reset_n)
      syn[0] |=> flags_r[CAA_BIT_DIVMIS];
  endproperty
  a_div: assert property (p_div) else $error("divider flag not set"); // R07

  property p_w1c;
    @(posedge clk) disable iff (!reset_n)
      (clr[CAA_BIT_PLL] && !fault_now[CAA_BIT_PLL]) |=> !flags_r[CAA_BIT_PLL];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // R08

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
      (flags_r[CAA_BIT_LINK] && !clr[CAA_BIT_LINK]) |=> flags_r[CAA_BIT_LINK];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // R13

  property p_rst;
    @(posedge clk) $rose(reset_n) |-> (flags_r == CAA_FLAGS_RST) && (mask_r == CAA_MASK_RST);
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong"); // R09 R11

  property p_ro;
    @(posedge clk) disable iff (!reset_n)
      (pready && !pwrite && hit(paddr, CAA_IDX_SUMMARY)) |-> prdata[31:1] == 31'h0;
  endproperty
  a_ro: assert property (p_ro) else $error("summary reserved bits set"); // R12

  property p_mask;
    @(posedge clk) disable iff (!reset_n)
      (mask_r == 5'h1F) |=> !calibration_status_pin;
  endproperty
  a_mask: assert property (p_mask) else $error("masked flag reached summary"); // R10

  property p_zero_keep;
    @(posedge clk) disable iff (!reset_n)
      (wr && hit(paddr, CAA_IDX_FLAGS) && (pwdata[4:0] == 5'h00)) |=>
        ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero write changed flags"); // R13

  property p_fault_wins;
    @(posedge clk) disable iff (!reset_n)
      (fault_now != 5'h00) |=> ((flags_r & $past(fault_now)) == $past(fault_now));
  endproperty
  a_fault_wins: assert property (p_fault_wins) else $error("present fault not kept"); // R13

  property p_mask_wr;
    @(posedge clk) disable iff (!reset_n)
      (wr && hit(paddr, CAA_IDX_MASK)) |=> (mask_r == $past(pwdata[4:0]));
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write not taken"); // R10

  // Reserved bits above the five flags must read back as zero
  property p_flags_rd;
    @(posedge clk) disable iff (!reset_n)
      (pready && !pwrite && !pslverr && hit(paddr, CAA_IDX_FLAGS)) |->
        (prdata == {27'h0000000, $past(flags_r)});
  endproperty
  a_flags_rd: assert property (p_flags_rd) else $error("flag read mismatch"); // R09

  property p_ready_pulse;
    @(posedge clk) disable iff (!reset_n)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

endmodule : caa_top

// file: sim/tb.sv
// Testbench: register-level checks of the converter alarm aggregator
`timescale 1ns/1ns
module tb;
  import caa_pkg::*;
  // ==========================================================================
  // Clock, reset and design
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [CAA_ADDR_W-1:0] paddr = '0;
  logic [31:0]           pwdata = '0, prdata, rdv;
  logic [3:0]            pstrb = 4'hF;
  logic                  pready, pslverr, erv, pin, irq;
  logic                  pll = 1'b1, lnk = 1'b1, enc = 1'b1;
  logic                  rea = 1'b0, syn = 1'b0, pha = 1'b0, dvm = 1'b0;
  int                    num_errors = 0;
  int                    checks_done = 0;
  logic [4:0]            fbit [7] = '{5'h01, 5'h02, 5'h02, 5'h02, 5'h04, 5'h08, 5'h10};

  always #50 clk = ~clk;

  caa_top caa_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_locked(pll), .serial_link_enable(lnk),
    .data_encoding_state(enc), .clock_realign_event(rea), .osc_sync_event(syn),
    .osc_phase_mismatch(pha), .divider_mismatch(dvm), .calibration_status_pin(pin),
    .irq(irq));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; waits for the answer, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge clk);
    chk({31'h0, pready}, 32'h0);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    pstrb  <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'hF);
    chk(rdv, exp);
  endtask : rd

  // Drives one fault cause; called just after a rising edge
  task automatic cause(input int k, input logic on);
    case (k)
      0: dvm <= on;
      1: pha <= on;
      2: syn <= on;
      3: lnk <= ~on;
      4: rea <= on;
      5: enc <= ~on;
      default: pll <= ~on;
    endcase
  endtask : cause

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(CAA_IDX_FLAGS, 32'h1F);
    rd(CAA_IDX_MASK, 32'h1F);
    rd(CAA_IDX_SUMMARY, 32'h0);
    wr(CAA_IDX_FLAGS, 32'h0);
    rd(CAA_IDX_FLAGS, 32'h1F);
    wr(CAA_IDX_FLAGS, 32'h1F);
    rd(CAA_IDX_FLAGS, 32'h0);
    wr(CAA_IDX_SEL, 32'h1);
    wr(CAA_IDX_IRQ_EN, 32'h1);
    wr(CAA_IDX_MASK, 32'h0);
    rd(CAA_IDX_MASK, 32'h0);
    // Every cause, each cleared before the next so the summary edges again
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      cause(k, 1'b1);
      repeat (5) @(posedge clk);
      cause(k, 1'b0);
      repeat (5) @(posedge clk);
      rd(CAA_IDX_FLAGS, {27'h0, fbit[k]});
      rd(CAA_IDX_SUMMARY, 32'h1);
      chk({31'h0, pin}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(CAA_IDX_IRQ_ST, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(CAA_IDX_FLAGS, {27'h0, fbit[k]});
      rd(CAA_IDX_FLAGS, 32'h0);
      rd(CAA_IDX_SUMMARY, 32'h0);
      chk({31'h0, pin}, 32'h0);
    end
    // Mask hides one flag only
    @(posedge clk);
    cause(4, 1'b1);
    repeat (5) @(posedge clk);
    cause(4, 1'b0);
    wr(CAA_IDX_MASK, 32'h04);
    rd(CAA_IDX_SUMMARY, 32'h0);
    wr(CAA_IDX_MASK, 32'h1B);
    rd(CAA_IDX_SUMMARY, 32'h1);
    wr(CAA_IDX_SUMMARY, 32'h0);
    rd(CAA_IDX_SUMMARY, 32'h1);
    // Write with byte lane 0 off is ignored
    apb(1'b1, CAA_IDX_FLAGS, 32'h1F, 4'hE);
    rd(CAA_IDX_FLAGS, 32'h04);
    wr(CAA_IDX_FLAGS, 32'h04);
    // Fault still present during the clearing write keeps the flag
    @(posedge clk);
    cause(6, 1'b1);
    repeat (5) @(posedge clk);
    wr(CAA_IDX_FLAGS, 32'h10);
    rd(CAA_IDX_FLAGS, 32'h10);
    @(posedge clk);
    cause(6, 1'b0);
    repeat (5) @(posedge clk);
    wr(CAA_IDX_FLAGS, 32'h10);
    rd(CAA_IDX_FLAGS, 32'h0);
    // Reset in mid-run brings flags and mask back
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(CAA_IDX_FLAGS, 32'h1F);
    rd(CAA_IDX_MASK, 32'h1F);
    rd(CAA_IDX_SUMMARY, 32'h0);
    rd(CAA_IDX_SEL, 32'h0);
    chk({31'h0, pin}, 32'h0);
    // Unmapped index answers with an error
    apb(1'b0, 12'h2C6, 32'h0, 4'hF);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    give_verdict();
  end

  // ==========================================================================
  // Watchdog: the sequence needs well under a millisecond
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule : tb
